// ### tmio_pkg.sv
// shared constants for the timer mode and i/o control block
package tmio_pkg;

  // ==========================================================
  // sizes
  // ==========================================================
  localparam int NUM_CH = 3; // channels 0 to 2
  localparam int SLOTS = 4; // general registers a..d per channel
  localparam int NSLOT = NUM_CH * SLOTS; // flat slot count
  localparam int DW = 16; // data, counter and general register width
  localparam int AW = 6; // register address width

  // ==========================================================
  // register offsets (word index on the plain port)
  // ==========================================================
  localparam logic [AW-1:0] OFS_START = 6'h00; // timer_start_reg
  localparam logic [AW-1:0] OFS_MODE0 = 6'h01; // channel_mode_reg ch0..2
  localparam logic [AW-1:0] OFS_IO0H = 6'h04; // ch0_io_control_high
  localparam logic [AW-1:0] OFS_IO0L = 6'h05; // ch0_io_control_low
  localparam logic [AW-1:0] OFS_IO1 = 6'h06; // ch1_io_control
  localparam logic [AW-1:0] OFS_IO2 = 6'h07; // ch2_io_control
  localparam logic [AW-1:0] OFS_STAT = 6'h08; // event status, w1c
  localparam logic [AW-1:0] OFS_MASK = 6'h09; // interrupt enable mask
  localparam logic [AW-1:0] OFS_CNT0 = 6'h0a; // channel_counter ch0..2
  localparam logic [AW-1:0] OFS_GR0 = 6'h10; // general regs, ch*4+slot

  // ==========================================================
  // field layouts
  // ==========================================================
  localparam int MODE_MSB = 2; // decoded mode bits 2..0
  localparam int MODE_B2 = 2; // mode_bit2
  localparam int MODE_B3 = 3; // mode_bit3_reserved
  localparam int BUF_AC_BIT = 4; // buffer_pair_ac
  localparam int BUF_BD_BIT = 5; // buffer_pair_bd
  localparam int IO_W = 4; // one io control field
  localparam int IO_LO_LSB = 0; // field a or c
  localparam int IO_HI_LSB = 4; // field b or d
  localparam logic [1:0] MODE_RSV_ONES = 2'h3; // mode bits 7..6 read 1
  localparam logic [7:0] IO_RST = 8'h00; // io control reset value
  localparam logic [3:0] MODE_RST = 4'h0; // mode field reset value

  // ==========================================================
  // operating modes (mode bits 2..0)
  // ==========================================================
  typedef enum logic [2:0] {
    TMIO_NORMAL = 3'h0,
    TMIO_RSVD = 3'h1,
    TMIO_PWM1 = 3'h2,
    TMIO_PWM2 = 3'h3,
    TMIO_PHASE1 = 3'h4,
    TMIO_PHASE2 = 3'h5,
    TMIO_PHASE3 = 3'h6,
    TMIO_PHASE4 = 3'h7
  } tmio_mode_e;

  // ==========================================================
  // i/o control codes
  // ==========================================================
  localparam int IO_CAP_BIT = 3; // 1: capture, 0: compare
  localparam int IO_INIT_BIT = 2; // compare: initial level
  localparam logic [1:0] ACT_OFF = 2'h0; // pin output disabled
  localparam logic [1:0] ACT_LOW = 2'h1; // drive low on match
  localparam logic [1:0] ACT_HIGH = 2'h2; // drive high on match
  localparam logic [1:0] ACT_TOG = 2'h3; // toggle on match
  localparam logic [3:0] IO_CAP_RISE = 4'h8; // capture rising edge
  localparam logic [3:0] IO_CAP_FALL = 4'h9; // capture falling edge
  localparam logic [2:0] IO_CAP_BOTH = 3'h5; // 101x both edges

endpackage

// ### tmio_core.sv
`timescale 1ns/1ns
//Function
//- decode three-bit mode field per channel
//- channel 0 lacks phase counting
//- channel 0 two io regs, others one
//- high/single register: b upper, a lower
//- channel 0 low register: d upper, c lower
//- initial level driven while counter stopped
//- pwm mode 2 level applied at clear
//- buffered c/d use io field only for o_pin_out level while stopped
//- codes 0000-0011 start low, match actions
//- codes 0100-0111 start high, match actions
//- capture on rising, falling or both edges
//- capture from own pin; 11xx prohibited
//- io fields read/write, reset to zero
//- buffer bits pair a with c, b with d
module tmio_core
  import tmio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rdata,
  input wire logic [NUM_CH-1:0] i_cnt_en,
  input wire logic [NSLOT-1:0] i_pin_in,
  output logic [NSLOT-1:0] o_pin_out,
  output logic [NSLOT-1:0] o_pin_oe,
  output logic o_irq
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [NUM_CH-1:0] start_ff; // counter_start_bit per channel
  logic [5:0] mode_ff [NUM_CH]; // buffer bits and mode bits 3..0
  logic [7:0] io_ff [4]; // 0h, 0l, 1, 2
  logic [NSLOT-1:0] stat_ff; // sticky events
  logic [NSLOT-1:0] mask_ff; // interrupt enables
  logic [DW-1:0] cnt_ff [NUM_CH]; // channel_counter
  logic [DW-1:0] gr_ff [NSLOT]; // general_reg_a..d
  logic [NSLOT-1:0] lvl_ff; // pin output level
  logic [NSLOT-1:0] sync1_ff; // pin synchroniser stage 1
  logic [NSLOT-1:0] sync2_ff; // pin synchroniser stage 2
  logic [NSLOT-1:0] prev_ff; // previous synced level
  logic [DW-1:0] rdata_ff; // read data, valid one cycle

  // ==========================================================
  // per-slot derived signals
  // ==========================================================
  logic [IO_W-1:0] io_code [NSLOT]; // io field for the slot
  logic [NSLOT-1:0] present; // slot exists in hardware
  logic [NSLOT-1:0] buffered; // slot acts as pure buffer
  logic [NSLOT-1:0] pair_buf; // a/b slot with buffer partner
  logic [NSLOT-1:0] is_cmp; // compare function active
  logic [NSLOT-1:0] match; // compare match this cycle
  logic [NSLOT-1:0] cap; // capture event this cycle
  logic [NSLOT-1:0] pwm2_clr; // counter cleared in pwm mode 2
  logic [NUM_CH-1:0] ch_clr; // per channel counter clear
  tmio_mode_e ch_mode [NUM_CH]; // decoded mode per channel

  // mode decode per channel
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      ch_mode[c] = tmio_mode_e'(mode_ff[c][MODE_MSB:0]);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSLOT; gi++)
    begin : g_slot
      localparam int CH = gi / SLOTS; // channel of this slot
      localparam int SL = gi % SLOTS; // 0 a, 1 b, 2 c, 3 d
      localparam int REG = (CH == 0) ? ((SL < 2) ? 0 : 1) : CH + 1;
      localparam int LSB = (SL % 2 == 0) ? IO_LO_LSB : IO_HI_LSB;
      localparam int BBIT = (SL % 2 == 0) ? BUF_AC_BIT : BUF_BD_BIT;

      // field select: a/c low nibble, b/d high nibble
      assign io_code[gi] = io_ff[REG][LSB +: IO_W];
      // ch1/ch2 only own a and b
      assign present[gi] = (CH == 0) || (SL < 2);
      // c/d become buffers of a/b when the pair bit is set
      assign buffered[gi] = (SL >= 2) && mode_ff[CH][BBIT];
      assign pair_buf[gi] = (CH == 0) && (SL < 2) && mode_ff[CH][BBIT];
      // compare function only for an unbuffered existing slot
      assign is_cmp[gi] = present[gi] && !buffered[gi]
                          && !io_code[gi][IO_CAP_BIT];
      // match while counting, counter equals register
      assign match[gi] = is_cmp[gi] && start_ff[CH] && i_cnt_en[CH]
                         && (cnt_ff[CH] == gr_ff[gi]);
      // capture edge select from the slot's own pin
      always_comb
      begin
        cap[gi] = 1'b0;
        if (present[gi] && !buffered[gi])
        begin
          if (io_code[gi] == IO_CAP_RISE)
            cap[gi] = sync2_ff[gi] && !prev_ff[gi];
          else if (io_code[gi] == IO_CAP_FALL)
            cap[gi] = !sync2_ff[gi] && prev_ff[gi];
          else if (io_code[gi][IO_W-1:1] == IO_CAP_BOTH)
            cap[gi] = sync2_ff[gi] ^ prev_ff[gi];
          else // compare codes and prohibited 11xx: none
            cap[gi] = 1'b0;
        end
      end
      // pwm mode 2 clear event of this slot's channel
      assign pwm2_clr[gi] = ch_clr[CH] && (ch_mode[CH] == TMIO_PWM2);
      // pin enable: compare with action other than disabled
      assign o_pin_oe[gi] = is_cmp[gi]
                            && (io_code[gi][1:0] != ACT_OFF);
      assign o_pin_out[gi] = lvl_ff[gi];
    end
  endgenerate

  // ==========================================================
  // pin synchronisers and edge history
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      sync1_ff <= i_pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // ==========================================================
  // channel counters
  // ==========================================================
  // pwm mode 2 clears the counter on general register a match
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      ch_clr[c] = (ch_mode[c] == TMIO_PWM2) && match[c*SLOTS];
    end
  end

  // count on the channel enable pulse while started
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int c = 0; c < NUM_CH; c++)
        cnt_ff[c] <= '0;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (i_wr && i_addr == OFS_CNT0 + AW'(c)) // software load
          cnt_ff[c] <= i_wdata;
        else if (start_ff[c] && i_cnt_en[c])
        begin
          if (ch_clr[c]) // cleared to zero
            cnt_ff[c] <= '0;
          else
            cnt_ff[c] <= cnt_ff[c] + DW'(1);
        end
      end
    end
  end

  // ==========================================================
  // control registers
  // ==========================================================
  // start bits
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      start_ff <= '0;
    else if (i_wr && i_addr == OFS_START)
      start_ff <= i_wdata[NUM_CH-1:0];
  end

  // mode registers; mode changes assumed with counter stopped
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int c = 0; c < NUM_CH; c++)
        mode_ff[c] <= {2'h0, MODE_RST};
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (i_wr && i_addr == OFS_MODE0 + AW'(c))
        begin
          mode_ff[c] <= i_wdata[5:0];
          if (c == 0) // no phase counting: bit 2 held low
            mode_ff[c][MODE_B2] <= 1'b0;
          if (c != 0) // no c/d: buffer bits stay zero
          begin
            mode_ff[c][BUF_AC_BIT] <= 1'b0;
            mode_ff[c][BUF_BD_BIT] <= 1'b0;
          end
        end
      end
    end
  end

  // io control registers, all fields read/write
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int r = 0; r < 4; r++)
        io_ff[r] <= IO_RST;
    end
    else
    begin
      for (int r = 0; r < 4; r++)
      begin
        if (i_wr && i_addr == OFS_IO0H + AW'(r))
          io_ff[r] <= i_wdata[7:0];
      end
    end
  end

  // ==========================================================
  // general registers: bus write, capture, buffer transfer
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int s = 0; s < NSLOT; s++)
        gr_ff[s] <= '0;
    end
    else
    begin
      for (int s = 0; s < NSLOT; s++)
      begin
        if (i_wr && i_addr == OFS_GR0 + AW'(s) && present[s])
          gr_ff[s] <= i_wdata;
        if (cap[s]) // capture the channel counter
          gr_ff[s] <= cnt_ff[s / SLOTS];
        // buffer pair: compare reloads from c/d
        // index wraps so the unrolled loop never leaves the array
        if (pair_buf[s] && match[s])
          gr_ff[s] <= gr_ff[(s + 2) % NSLOT];
        // buffer pair: capture pushes old value into c/d
        if (pair_buf[s] && cap[s])
          gr_ff[(s + 2) % NSLOT] <= gr_ff[s];
      end
    end
  end

  // ==========================================================
  // pin output levels
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      lvl_ff <= '0;
    else
    begin
      for (int s = 0; s < NSLOT; s++)
      begin
        if (!start_ff[s / SLOTS]) // stopped: initial level
          lvl_ff[s] <= io_code[s][IO_INIT_BIT];
        else if (match[s])
        begin
          case (io_code[s][1:0])
            ACT_LOW: lvl_ff[s] <= 1'b0;
            ACT_HIGH: lvl_ff[s] <= 1'b1;
            ACT_TOG: lvl_ff[s] <= !lvl_ff[s];
            default: lvl_ff[s] <= lvl_ff[s];
          endcase
        end
        else if (pwm2_clr[s] && is_cmp[s]) // level at counter clear
          lvl_ff[s] <= io_code[s][IO_INIT_BIT];
      end
    end
  end

  // ==========================================================
  // events and interrupt
  // ==========================================================
  // sticky status, write one to clear, set wins
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      stat_ff <= '0;
    else
    begin
      for (int s = 0; s < NSLOT; s++)
      begin
        if (match[s] || cap[s])
          stat_ff[s] <= 1'b1;
        else if (i_wr && i_addr == OFS_STAT && i_wdata[s])
          stat_ff[s] <= 1'b0;
      end
    end
  end

  // interrupt mask, absent slots held off
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      mask_ff <= '0;
    else if (i_wr && i_addr == OFS_MASK)
      mask_ff <= i_wdata[NSLOT-1:0] & present;
  end

  assign o_irq = |(stat_ff & mask_ff);

  // ==========================================================
  // read port
  // ==========================================================
  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_ff <= '0;
    else
    begin
      rdata_ff <= '0;
      if (i_rd)
      begin
        if (i_addr == OFS_START)
          rdata_ff <= DW'(start_ff);
        else if (i_addr >= OFS_MODE0 && i_addr < OFS_IO0H)
          rdata_ff <= DW'({MODE_RSV_ONES, mode_ff[2'(i_addr - OFS_MODE0)]});
        else if (i_addr >= OFS_IO0H && i_addr < OFS_STAT)
          rdata_ff <= DW'(io_ff[2'(i_addr - OFS_IO0H)]);
        else if (i_addr == OFS_STAT)
          rdata_ff <= DW'(stat_ff);
        else if (i_addr == OFS_MASK)
          rdata_ff <= DW'(mask_ff);
        else if (i_addr >= OFS_CNT0 && i_addr < OFS_CNT0 + AW'(NUM_CH))
          rdata_ff <= cnt_ff[2'(i_addr - OFS_CNT0)];
        else if (i_addr >= OFS_GR0 && i_addr < OFS_GR0 + AW'(NSLOT))
          rdata_ff <= gr_ff[4'(i_addr - OFS_GR0)];
        else // unmapped reads zero
          rdata_ff <= '0;
      end
    end
  end

  assign o_rdata = rdata_ff;

endmodule

// ### tmio_monitor.sv
`timescale 1ns/1ns
// ==========================================================
// port checker for the core
// ==========================================================
module tmio_monitor
  import tmio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DW-1:0] o_rdata,
  input wire logic [NUM_CH-1:0] i_cnt_en,
  input wire logic [NSLOT-1:0] i_pin_in,
  input wire logic [NSLOT-1:0] o_pin_out,
  input wire logic [NSLOT-1:0] o_pin_oe,
  input wire logic o_irq
);
  logic [7:0] io_sh [4]; // shadow io control regs
  logic [7:0] md0_sh; // shadow ch0 mode
  logic [2:0] st_sh; // shadow start bits
  logic [3:0] fa0; // slot 0 code
  logic [3:0] fa4; // slot 4 code
  logic [7:0] io_rd; // shadow at read address
  logic io_hit; // io control read
  logic md_hit; // ch0 mode read
  logic msk_zero; // mask cleared
  // shadows follow bus writes
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      io_sh <= '{default: 8'h00};
      md0_sh <= 8'h00;
      st_sh <= 3'h0;
    end
    else if (i_wr)
    begin
      if (i_addr[5:2] == 4'h1)
        io_sh[i_addr[1:0]] <= i_wdata[7:0];
      if (i_addr == OFS_MODE0)
        md0_sh <= i_wdata[7:0];
      if (i_addr == OFS_START)
        st_sh <= i_wdata[2:0];
    end
  end
  assign fa0 = io_sh[0][3:0];
  assign fa4 = io_sh[2][3:0];
  assign io_rd = io_sh[i_addr[1:0]];
  assign io_hit = i_rd && i_addr[5:2] == 4'h1;
  assign md_hit = i_rd && i_addr == OFS_MODE0;
  assign msk_zero = i_wr && i_addr == OFS_MASK && i_wdata == '0;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  chk_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero while idle");
  chk_io_readback: assert property
    ($past(io_hit) |-> o_rdata == {8'h00, $past(io_rd)})
    else $error("io control read back wrong");
  chk_ch0_mode_bits: assert property
    ($past(md_hit) |-> !o_rdata[MODE_B2] && o_rdata[7:6] == 2'h3)
    else $error("ch0 mode bits wrong");
  chk_oe_off_code: assert property
    (!fa4[3] && fa4[1:0] == 2'h0 |-> !o_pin_oe[4])
    else $error("disabled code drives pin");
  chk_oe_capture: assert property (fa4[3] |-> !o_pin_oe[4])
    else $error("capture code drives pin");
  chk_init_level: assert property
    (!st_sh[0] && $stable(st_sh) && $stable(fa0) && !fa0[3] &&
      fa0[1:0] != 2'h0 |-> o_pin_oe[0] && o_pin_out[0] == fa0[2])
    else $error("initial level wrong while stopped");
  chk_buf_no_oe: assert property (md0_sh[BUF_AC_BIT] |-> !o_pin_oe[2])
    else $error("buffered register drives pin");
  chk_missing_slots: assert property
    (o_pin_oe[7:6] == 2'h0 && o_pin_oe[11:10] == 2'h0)
    else $error("absent slot drives pin");
  chk_irq_masked: assert property ($past(msk_zero) |-> !o_irq)
    else $error("irq high with mask clear");
  cover property ($rose(o_irq));
  cover property ($past(io_hit) && o_rdata != '0);
  cover property (o_pin_oe[4] && $rose(o_pin_out[4]));
endmodule
bind tmio_core tmio_monitor mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_cnt_en(i_cnt_en), .i_pin_in(i_pin_in),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

// ### tmio_pins.sv
`timescale 1ns/1ns
// ==========================================================
// external pins: capture sources and compare loads
// ==========================================================
module tmio_pins
  import tmio_pkg::*;
(
  input wire logic i_clk,
  input wire logic [NSLOT-1:0] i_oe,
  input wire logic [NSLOT-1:0] i_out,
  output logic [NSLOT-1:0] o_pin
);
  logic [NSLOT-1:0] ext_ff = '0; // levels set by outside sources
  // change one pin level after a clock edge
  task automatic drive(input int idx, input logic v);
    @(posedge i_clk);
    ext_ff[idx] <= v;
  endtask
  // each slot sees only its own pin
  assign o_pin = (i_oe & i_out) | (~i_oe & ext_ff);
endmodule

// ### tmio_core_test.sv
`timescale 1ns/1ns
// ==========================================================
// bench for the core
// ==========================================================
module tmio_core_test
  import tmio_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [AW-1:0] i_addr = '0;
  logic [DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [NUM_CH-1:0] i_cnt_en = '0;
  logic [DW-1:0] o_rdata;
  logic [NSLOT-1:0] i_pin_in;
  logic [NSLOT-1:0] o_pin_out;
  logic [NSLOT-1:0] o_pin_oe;
  logic o_irq;
  logic [DW-1:0] rv; // read value
  logic rs; // rising capture expected
  logic fl; // falling capture expected
  int miscompares = 0;
  int n_tests = 0;
  int i;
  tmio_core dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cnt_en(i_cnt_en), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_irq(o_irq));
  tmio_pins pins (.i_clk(i_clk), .i_oe(o_pin_oe), .i_out(o_pin_out),
    .o_pin(i_pin_in));
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  // ========================================================
  // tasks
  // ========================================================
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  // one count enable pulse, pins settle after it
  task automatic pulse(input logic [NUM_CH-1:0] m);
    @(posedge i_clk);
    i_cnt_en <= m;
    @(posedge i_clk);
    i_cnt_en <= '0;
    #1;
  endtask
  // hang guard
  initial
  begin
    tick(20000);
    miscompares++;
    end_of_test();
  end
  // ========================================================
  // main sequence
  // ========================================================
  initial
  begin
    tick(8);
    i_nrst <= 1'b1;
    for (i = 4; i < 8; i++)
      rc(6'(i), 16'h0000);
    rc(OFS_MODE0, 16'h00c0);
    rc(6'h3f, 16'h0000);
    wr(OFS_IO0H, 16'h0025);
    wr(OFS_IO0L, 16'h0043);
    rc(OFS_IO0H, 16'h0025);
    rc(OFS_IO0L, 16'h0043);
    for (i = 0; i < 8; i++)
    begin
      wr(OFS_MODE0 + 6'h02, 16'(i));
      rc(OFS_MODE0 + 6'h02, 16'h00c0 | 16'(i));
    end
    $display("registers done");
    wr(OFS_IO0L, 16'h0001);
    wr(OFS_MODE0, 16'h0014);
    rc(OFS_MODE0, 16'h00d0);
    chb(o_pin_oe[2], 1'b0);
    wr(OFS_MODE0, 16'h0000);
    tick(2);
    chb(o_pin_oe[2], 1'b1);
    $display("buffer done");
    for (i = 0; i < 8; i++)
    begin
      wr(OFS_START, 16'h0000);
      wr(OFS_IO1, 16'(i));
      tick(2);
      chb(o_pin_oe[4], i % 4 != 0);
      if (i % 4 != 0)
      begin
        chb(o_pin_out[4], i[2]);
        wr(OFS_GR0 + 6'h04, 16'h0005);
        wr(OFS_CNT0 + 6'h01, 16'h0005);
        wr(OFS_START, 16'h0002);
        pulse(3'h2);
        chb(o_pin_out[4], i % 4 == 1 ? 1'b0 : i % 4 == 2 | !i[2]);
        rc(OFS_STAT, 16'h0010);
        wr(OFS_STAT, 16'h0010);
      end
    end
    $display("compare done");
    // pwm mode 2: a clears the counter, b reloads its level
    wr(OFS_START, 16'h0000);
    wr(OFS_MODE0 + 6'h01, 16'h0003);
    wr(OFS_IO1, 16'h0051);
    wr(OFS_GR0 + 6'h04, 16'h0003);
    wr(OFS_GR0 + 6'h05, 16'h0001);
    wr(OFS_CNT0 + 6'h01, 16'h0001);
    wr(OFS_START, 16'h0002);
    pulse(3'h2);
    chb(o_pin_out[5], 1'b0);
    pulse(3'h2);
    pulse(3'h2);
    chb(o_pin_out[5], 1'b1);
    rc(OFS_CNT0 + 6'h01, 16'h0000);
    wr(OFS_START, 16'h0000);
    wr(OFS_MODE0 + 6'h01, 16'h0000);
    wr(OFS_IO1, 16'h0000);
    $display("pwm done");
    for (i = 8; i < 13; i++)
    begin
      rs = i != 9 && i < 12;
      fl = i > 8 && i < 12;
      wr(OFS_IO1, 16'(i << 4));
      wr(OFS_GR0 + 6'h05, 16'h0000);
      wr(OFS_CNT0 + 6'h01, 16'h0011);
      pins.drive(5, 1'b1);
      tick(4);
      rc(OFS_GR0 + 6'h05, rs ? 16'h0011 : 16'h0000);
      wr(OFS_CNT0 + 6'h01, 16'h0022);
      pins.drive(5, 1'b0);
      tick(4);
      rc(OFS_GR0 + 6'h05, fl ? 16'h0022 : {11'h0, rs, 3'h0, rs});
    end
    $display("capture done");
    wr(OFS_MASK, 16'h0020);
    chb(o_irq, 1'b1);
    wr(OFS_MASK, 16'h0000);
    chb(o_irq, 1'b0);
    wr(OFS_MASK, 16'h0020);
    wr(OFS_STAT, 16'h0020);
    chb(o_irq, 1'b0);
    $display("interrupt done");
    end_of_test();
  end
endmodule
